// [src/energy_detect_pkg.sv]
// Package of register layout, reset values and timing for the energy-detect power control.
package energy_detect_pkg;
   // ==========================================================================
   // Register map
   localparam logic [4:0] energy_detect_control_status_addr = 5'h1d;
   localparam int bit_allow = 15;
   localparam int bit_auto_up = 14;
   localparam int bit_auto_down = 13;
   localparam int bit_manual = 12;
   localparam int bit_burst_dis = 11;
   localparam int bit_power_state = 10;
   localparam int bit_err_met = 9;
   localparam int bit_data_met = 8;
   localparam int err_thr_lsb = 4;
   localparam int data_thr_lsb = 0;
   localparam logic [3:0] threshold_reset = 4'h1;
   localparam logic [2:0] burst_pulses = 3'h4;
   localparam logic [2:0] single_pulse = 3'h1;
   localparam logic [1:0] strap_settle = 2'h2;
   // ==========================================================================
   // Timing
   localparam longint clk_hz = 20000000;
   localparam longint quiet_time_ms = 2000;
   localparam longint quiet_cycles_calc = (clk_hz * quiet_time_ms) / 1000;
   localparam logic [31:0] quiet_cycles = quiet_cycles_calc[31:0];
   localparam int quiet_cycles_int = 40000000;

   // Management access from the serial management engine.
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } mgmt_req_t;

   // Events seen on the cable.
   typedef struct packed
   {
      logic data_event;
      logic error_event;
      logic energy_present;
   } line_event_t;

   typedef enum logic [1:0] {st_down, st_up} power_state_t;

   typedef struct packed
   {
      logic allow;
      logic auto_up;
      logic auto_down;
      logic manual;
      logic burst_dis;
      power_state_t state;
      logic err_met;
      logic data_met;
      logic [3:0] err_thr;
      logic [3:0] data_thr;
      logic [3:0] data_cnt;
      logic [3:0] err_cnt;
      logic [31:0] quiet_cnt;
      logic [2:0] pulses_left;
      logic [15:0] rdata;
      logic strap_taken;
      logic strap_s1;
      logic strap_s2;
      logic [1:0] strap_age;
      line_event_t ev_s1;
      line_event_t ev_s2;
   } ed_state_t;

   // Saturating four-bit count increment.
   function automatic logic [3:0] sat_inc(input logic [3:0] v);
      sat_inc = (v == 4'hf) ? v : v + 4'h1;
   endfunction
endpackage

// [src/energy_detect_power_control.sv]
// Energy-detect power control for one transceiver port.
// Overview of operation
// - Strap-reset enable bit gates energy detect
// - Auto power-up when data count meets threshold
// - Auto power-down once energy disappears
// - Self-clearing manual bit toggles power state
// - Send four pulses, one if burst disabled
// - Read-only bit shows current power state
// - Error flag clear-on-read, informational only
// - Data flag sets when count meets threshold
// - Error threshold field resets to one
// - Data threshold field resets to one
// - Counters clear after two quiet seconds
module energy_detect_power_control
   import energy_detect_pkg::*;
#(
   parameter logic [31:0] quiet_limit = quiet_cycles
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic strap_allow,
   input wire mgmt_req_t mgmt,
   output logic [15:0] mgmt_rdata,
   input wire line_event_t line_in,
   output logic line_driver_power,
   output logic pulse_strobe
);
   ed_state_t cur_ff;
   ed_state_t nxt_ff;
   logic access;
   logic data_hit;
   logic err_hit;
   logic manual_go;
   logic [15:0] reg_img;

   // ==========================================================================
   // Next-state logic
   always_comb
   begin
      nxt_ff = cur_ff;
      access = (mgmt.addr == energy_detect_control_status_addr);
      // ======================================================================
      // Input synchronisers
      nxt_ff.ev_s1 = line_in;
      nxt_ff.ev_s2 = cur_ff.ev_s1;
      nxt_ff.strap_s1 = strap_allow;
      nxt_ff.strap_s2 = cur_ff.strap_s1;
      // The strap is taken once its second flip-flop holds a settled level.
      if (cur_ff.strap_age != strap_settle)
         nxt_ff.strap_age = cur_ff.strap_age + 2'h1;
      else if (!cur_ff.strap_taken)
      begin
         nxt_ff.allow = cur_ff.strap_s2;
         nxt_ff.strap_taken = 1'b1;
      end
      // ======================================================================
      // Event counters
      // Counters count events and stick at full scale.
      if (cur_ff.ev_s2.data_event)
         nxt_ff.data_cnt = sat_inc(cur_ff.data_cnt);
      if (cur_ff.ev_s2.error_event)
         nxt_ff.err_cnt = sat_inc(cur_ff.err_cnt);
      if (cur_ff.ev_s2.data_event)
         nxt_ff.quiet_cnt = 32'h0000_0000;
      else if (cur_ff.quiet_cnt >= quiet_limit - 32'h0000_0001)
      begin
         nxt_ff.quiet_cnt = 32'h0000_0000;
         nxt_ff.data_cnt = 4'h0;
         nxt_ff.err_cnt = 4'h0;
      end
      else
         nxt_ff.quiet_cnt = cur_ff.quiet_cnt + 32'h0000_0001;
      data_hit = (cur_ff.data_cnt >= cur_ff.data_thr);
      err_hit = (cur_ff.err_cnt >= cur_ff.err_thr);
      manual_go = cur_ff.manual;
      nxt_ff.manual = 1'b0;
      // ======================================================================
      // Register access
      reg_img = 16'h0000;
      reg_img[bit_allow] = cur_ff.allow;
      reg_img[bit_auto_up] = cur_ff.auto_up;
      reg_img[bit_auto_down] = cur_ff.auto_down;
      reg_img[bit_manual] = cur_ff.manual;
      reg_img[bit_burst_dis] = cur_ff.burst_dis;
      reg_img[bit_power_state] = (cur_ff.state == st_up);
      reg_img[bit_err_met] = cur_ff.err_met;
      reg_img[bit_data_met] = cur_ff.data_met;
      reg_img[err_thr_lsb +: 4] = cur_ff.err_thr;
      reg_img[data_thr_lsb +: 4] = cur_ff.data_thr;
      // Read returns the register image, then clears the met flags.
      nxt_ff.rdata = cur_ff.rdata;
      if (mgmt.rd && access)
      begin
         nxt_ff.rdata = reg_img;
         nxt_ff.err_met = 1'b0;
         nxt_ff.data_met = 1'b0;
      end
      // A threshold crossing in the read cycle is kept: set wins.
      if (err_hit)
         nxt_ff.err_met = 1'b1;
      if (data_hit)
         nxt_ff.data_met = 1'b1;
      if (mgmt.wr && access)
      begin
         nxt_ff.allow = mgmt.wdata[bit_allow];
         nxt_ff.auto_up = mgmt.wdata[bit_auto_up];
         nxt_ff.auto_down = mgmt.wdata[bit_auto_down];
         nxt_ff.manual = mgmt.wdata[bit_manual];
         nxt_ff.burst_dis = mgmt.wdata[bit_burst_dis];
         nxt_ff.err_thr = mgmt.wdata[err_thr_lsb +: 4];
         nxt_ff.data_thr = mgmt.wdata[data_thr_lsb +: 4];
      end
      if (cur_ff.pulses_left != 3'h0)
         nxt_ff.pulses_left = cur_ff.pulses_left - 3'h1;
      // ======================================================================
      // Power state
      // Power state machine; manual toggle ignores thresholds and timers.
      if (cur_ff.allow)
      begin
         unique case (cur_ff.state)
            st_down:
            begin
               if (manual_go || (cur_ff.auto_up && data_hit))
               begin
                  nxt_ff.state = st_up;
                  nxt_ff.pulses_left = cur_ff.burst_dis ? single_pulse : burst_pulses;
                  nxt_ff.data_cnt = 4'h0;
               end
            end
            st_up:
            begin
               if (manual_go || (cur_ff.auto_down && !cur_ff.ev_s2.energy_present))
                  nxt_ff.state = st_down;
            end
            default:
               nxt_ff.state = st_down;
         endcase
      end
      else
         nxt_ff.state = st_up;
   end

   // ==========================================================================
   // State register
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cur_ff <= '0;
         cur_ff.auto_up <= 1'b1;
         cur_ff.auto_down <= 1'b1;
         cur_ff.err_thr <= threshold_reset;
         cur_ff.data_thr <= threshold_reset;
         cur_ff.state <= st_up;
      end
      else if (clk_en)
         cur_ff <= nxt_ff;
   end

   assign mgmt_rdata = cur_ff.rdata;
   assign line_driver_power = (cur_ff.state == st_up);
   assign pulse_strobe = (cur_ff.pulses_left != 3'h0);

   // ==========================================================================
   // Checks
   // Manual toggle pending while powered down.
   sequence s_manual_down;
      clk_en && cur_ff.manual && cur_ff.allow && cur_ff.state == st_down;
   endsequence

   // Manual toggle pending while powered up.
   sequence s_manual_up;
      clk_en && cur_ff.manual && cur_ff.allow && cur_ff.state == st_up;
   endsequence

   // Power-up edge with the full burst selected.
   sequence s_rise_burst;
      clk_en && $rose(line_driver_power) && $past(cur_ff.allow) && !$past(cur_ff.burst_dis);
   endsequence

   // Power-up edge with a single pulse selected.
   sequence s_rise_single;
      clk_en && $rose(line_driver_power) && $past(cur_ff.allow) && $past(cur_ff.burst_dis);
   endsequence

   // ==========================================================================
   // Power state checks
   a_manual_self_clear: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.manual |=> !cur_ff.manual || $past(mgmt.wr))
      else $error("manual bit did not self clear");

   a_manual_forces_up: assert property (@(posedge sys_clk) disable iff (rst)
      s_manual_down |=> cur_ff.state == st_up)
      else $error("manual toggle did not power up");

   a_manual_forces_down: assert property (@(posedge sys_clk) disable iff (rst)
      s_manual_up |=> cur_ff.state == st_down)
      else $error("manual toggle did not power down");

   a_auto_up_count: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.allow && cur_ff.auto_up && cur_ff.state == st_down
      && cur_ff.data_cnt >= cur_ff.data_thr |=> cur_ff.state == st_up)
      else $error("no power up at data threshold");

   a_auto_down_quiet: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.allow && cur_ff.auto_down && cur_ff.state == st_up
      && !cur_ff.ev_s2.energy_present |=> cur_ff.state == st_down)
      else $error("no power down on silence");

   a_down_held: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.allow && !cur_ff.manual && cur_ff.state == st_down && !data_hit
      |=> cur_ff.state == st_down)
      else $error("power up without data threshold or manual toggle");

   a_up_held: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.allow && !cur_ff.manual && cur_ff.state == st_up
      && cur_ff.ev_s2.energy_present |=> cur_ff.state == st_up)
      else $error("power down while energy present");

   a_disabled_held_up: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && !cur_ff.allow |=> cur_ff.state == st_up)
      else $error("state moved while detect disabled");

   // ==========================================================================
   // Pulse burst checks
   a_burst_length: assert property (@(posedge sys_clk) disable iff (rst)
      s_rise_burst |-> cur_ff.pulses_left == burst_pulses)
      else $error("burst length wrong");

   a_pulse_single: assert property (@(posedge sys_clk) disable iff (rst)
      s_rise_single |-> cur_ff.pulses_left == single_pulse)
      else $error("single pulse length wrong");

   a_pulse_count_down: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.state == st_up && cur_ff.pulses_left != 3'h0
      |=> cur_ff.pulses_left == $past(cur_ff.pulses_left) - 3'h1)
      else $error("pulse count did not step down");

   // ==========================================================================
   // Counter checks
   a_data_met_set: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.data_cnt >= cur_ff.data_thr |=> cur_ff.data_met)
      else $error("data met flag not set");

   a_err_met_set: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.err_cnt >= cur_ff.err_thr |=> cur_ff.err_met)
      else $error("error met flag not set");

   a_quiet_clear: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && !cur_ff.ev_s2.data_event && cur_ff.quiet_cnt == quiet_limit - 32'h0000_0001
      |=> cur_ff.data_cnt == 4'h0 && cur_ff.err_cnt == 4'h0)
      else $error("counters not cleared after quiet time");

   a_quiet_restart: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.ev_s2.data_event |=> cur_ff.quiet_cnt == 32'h0000_0000)
      else $error("quiet timer not restarted by data event");

   a_data_cnt_step: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.ev_s2.data_event && cur_ff.state == st_up && cur_ff.data_cnt != 4'hf
      |=> cur_ff.data_cnt == $past(cur_ff.data_cnt) + 4'h1)
      else $error("data counter did not count");

   a_err_cnt_step: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.ev_s2.error_event && cur_ff.err_cnt != 4'hf
      && (cur_ff.ev_s2.data_event || cur_ff.quiet_cnt < quiet_limit - 32'h0000_0001)
      |=> cur_ff.err_cnt == $past(cur_ff.err_cnt) + 4'h1)
      else $error("error counter did not count");

   a_up_clears_data: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.allow && cur_ff.state == st_down
      && (cur_ff.manual || (cur_ff.auto_up && data_hit)) |=> cur_ff.data_cnt == 4'h0)
      else $error("data counter not cleared at power up");

   // ==========================================================================
   // Register access checks
   a_state_readback: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && mgmt.rd && access |=> mgmt_rdata[bit_power_state] == $past(line_driver_power))
      else $error("power state readback wrong");

   a_read_clears_err: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && mgmt.rd && access && !err_hit |=> !cur_ff.err_met)
      else $error("error met flag not cleared by read");

   a_read_clears_data: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && mgmt.rd && access && !data_hit |=> !cur_ff.data_met)
      else $error("data met flag not cleared by read");

   a_strap_taken: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && cur_ff.strap_age == strap_settle && !cur_ff.strap_taken
      && !(mgmt.wr && access) |=> cur_ff.allow == $past(cur_ff.strap_s2))
      else $error("strap level not taken into enable bit");

   a_allow_write: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && mgmt.wr && access |=> cur_ff.allow == $past(mgmt.wdata[bit_allow]))
      else $error("enable bit not written");

   a_err_thr_write: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && mgmt.wr && access |=> cur_ff.err_thr == $past(mgmt.wdata[err_thr_lsb +: 4]))
      else $error("error threshold not written");

   a_data_thr_write: assert property (@(posedge sys_clk) disable iff (rst)
      clk_en && mgmt.wr && access |=> cur_ff.data_thr == $past(mgmt.wdata[data_thr_lsb +: 4]))
      else $error("data threshold not written");
endmodule

// [dv/line_partner.sv]
// Cable-side model that raises data, error and energy events.
module line_partner
   import energy_detect_pkg::*;
(
   input wire logic sys_clk,
   output line_event_t line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // The cable starts idle with energy present on the line.
   initial line_out = '{1'b0, 1'b0, 1'b1};
   // ==========
   // Sends n single-cycle events, each followed by a quiet cycle.
   task automatic burst(input logic is_err, input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         #5 line_out.data_event = !is_err;
         line_out.error_event = is_err;
         @(posedge sys_clk);
         #5 line_out.data_event = 1'b0;
         line_out.error_event = 1'b0;
      end
   endtask
   task automatic energy(input logic on);
      @(posedge sys_clk);
      #5 line_out.energy_present = on;
   endtask
endmodule

// [dv/energy_detect_power_control_test.sv]
// Bench for the energy-detect power control.
module energy_detect_power_control_test
   import energy_detect_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0;
   logic rst = 1;
   logic strap_allow = 1;
   mgmt_req_t mgmt = '0;
   logic [15:0] mgmt_rdata;
   line_event_t line_in;
   logic line_driver_power;
   logic pulse_strobe;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #25 sys_clk = ~sys_clk;
   energy_detect_power_control #(.quiet_limit(32'h0000_0032)) dut (.sys_clk(sys_clk), .rst(rst),
      .clk_en(1'b1), .strap_allow(strap_allow), .mgmt(mgmt), .mgmt_rdata(mgmt_rdata),
      .line_in(line_in), .line_driver_power(line_driver_power), .pulse_strobe(pulse_strobe));
   line_partner far (.sys_clk(sys_clk), .line_out(line_in));
   // ==========
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] d);
      @(posedge sys_clk);
      #5 mgmt = '{1'b1, 1'b0, energy_detect_control_status_addr, d};
      @(posedge sys_clk);
      #5 mgmt = '0;
   endtask
   task automatic rd(input logic [15:0] exp);
      @(posedge sys_clk);
      #5 mgmt = '{1'b0, 1'b1, energy_detect_control_status_addr, 16'h0000};
      @(posedge sys_clk);
      #5 mgmt = '0;
      check(mgmt_rdata, exp);
   endtask
   task automatic pulses(input logic [15:0] exp);
      int n;
      n = 0;
      repeat (16)
      begin
         @(posedge sys_clk);
         #5 n += int'(pulse_strobe);
      end
      check(16'(n), exp);
   endtask
   task automatic final_report();
      $display("compares=%0d errors=%0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ==========
   task automatic t_reset();
      rd(16'he411);
   endtask
   task automatic t_down();
      far.energy(1'b0);
      repeat (6) @(posedge sys_clk);
      #5 check({15'h0, line_driver_power}, 16'h0000);
      rd(16'he011);
   endtask
   task automatic t_up();
      far.energy(1'b1);
      far.burst(1'b0, 1);
      pulses(16'h0004);
      check({15'h0, line_driver_power}, 16'h0001);
      rd(16'he511);
      rd(16'he411);
   endtask
   task automatic t_manual();
      wr(16'hf811);
      repeat (3) @(posedge sys_clk);
      #5 check({15'h0, line_driver_power}, 16'h0000);
      rd(16'he811);
      wr(16'hf811);
      pulses(16'h0001);
      rd(16'hec11);
   endtask
   task automatic t_error();
      wr(16'he021);
      far.burst(1'b0, 1);
      far.burst(1'b1, 2);
      repeat (4) @(posedge sys_clk);
      rd(16'he721);
      repeat (60) @(posedge sys_clk);
      rd(16'he721);
      rd(16'he421);
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         err_total++;
         final_report();
      end
   end
   initial
   begin
      repeat (5) @(posedge sys_clk);
      #5 rst = 0;
      repeat (3) @(posedge sys_clk);
      t_reset();
      t_down();
      t_up();
      t_manual();
      t_error();
      final_report();
   end
endmodule
